// File: logic/mmupe_defs.svh
// mmupe_defs.svh: offsets, field positions and reset values of the mmu page entry staging registers
// assumes: included by bare name from the package and the design modules
`ifndef MMUPE_DEFS_SVH
`define MMUPE_DEFS_SVH

// register offsets inside the mmu register block (byte addresses)
`define MMUPE_ADDR_W 8
`define MMUPE_OFS_ENTRY_LOW 8'h04
`define MMUPE_OFS_TABLE_BASE 8'h08
`define MMUPE_OFS_EXC_ADDR 8'h0C

// page entry low field layout
`define MMUPE_PPN_MSB 28
`define MMUPE_PPN_LSB 10
`define MMUPE_VALID_BIT 8
`define MMUPE_ATTR_MSB 7
`define MMUPE_ATTR_LSB 0
`define MMUPE_ENTRY_LOW_MASK 32'h1FFF_FDFF

// entry high field widths as handed to the tlb
`define MMUPE_VPN_W 22
`define MMUPE_ADDRESS_SPACE_ID_W 8

// reset values
`define MMUPE_ENTRY_LOW_RST 32'h0000_0000
`define MMUPE_TABLE_BASE_RST 32'h0000_0000
`define MMUPE_EXC_ADDR_RST 32'h0000_0000
`define MMUPE_RDATA_RST 32'h0000_0000

`endif

// File: logic/mmupe_pkg.sv
// mmupe_pkg.sv: types shared by the mmu page entry staging registers
// assumes: mmupe_defs.svh is on the include path
`include "mmupe_defs.svh"

package mmupe_pkg;

	// which register an access offset selects
	typedef enum logic [1:0] {
		MMUPE_SEL_NONE,
		MMUPE_SEL_ENTRY_LOW,
		MMUPE_SEL_TABLE_BASE,
		MMUPE_SEL_EXC_ADDR
	} mmupe_sel_type;

	typedef logic [`MMUPE_ADDR_W-1:0] mmupe_addr_type;
	typedef logic [31:0] mmupe_word_type;

	// offset decode, used by both the write and the read path
	function automatic mmupe_sel_type mmupe_decode(input mmupe_addr_type addr);
		case (addr)
			`MMUPE_OFS_ENTRY_LOW: mmupe_decode = MMUPE_SEL_ENTRY_LOW;
			`MMUPE_OFS_TABLE_BASE: mmupe_decode = MMUPE_SEL_TABLE_BASE;
			`MMUPE_OFS_EXC_ADDR: mmupe_decode = MMUPE_SEL_EXC_ADDR;
			default: mmupe_decode = MMUPE_SEL_NONE;
		endcase
	endfunction : mmupe_decode

endpackage : mmupe_pkg

// File: logic/mmupe_tlb_load.sv
// mmupe_tlb_load.sv: builds one unified tlb write from the staged entry on a load-tlb instruction
// assumes: same clock as the core; load pulse lasts one cycle; the tlb picks the entry itself
`include "mmupe_defs.svh"

module mmupe_tlb_load
	import mmupe_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// staged entry
	input wire logic load,
	input wire logic [31:0] entry_low,
	input wire logic [`MMUPE_VPN_W-1:0] virtual_page_number,
	input wire logic [`MMUPE_ADDRESS_SPACE_ID_W-1:0] address_space_id,
	// tlb write
	output logic wr,
	output logic [`MMUPE_PPN_MSB-`MMUPE_PPN_LSB:0] physical_page_number,
	output logic valid,
	output logic [`MMUPE_ATTR_MSB:0] attr,
	output logic [`MMUPE_VPN_W-1:0] wr_vpn,
	output logic [`MMUPE_ADDRESS_SPACE_ID_W-1:0] wr_address_space_id
);

	logic next_wr;
	logic [`MMUPE_PPN_MSB-`MMUPE_PPN_LSB:0] next_ppn;
	logic next_valid;
	logic [`MMUPE_ATTR_MSB:0] next_attr;
	logic [`MMUPE_VPN_W-1:0] next_vpn;
	logic [`MMUPE_ADDRESS_SPACE_ID_W-1:0] next_address_space_id;

	// fields are latched only on a load so the tlb sees a stable entry between loads
	always_comb begin
		next_wr = load;
		next_ppn = physical_page_number;
		next_valid = valid;
		next_attr = attr;
		next_vpn = wr_vpn;
		next_address_space_id = wr_address_space_id;
		if (load) begin
			next_ppn = entry_low[`MMUPE_PPN_MSB:`MMUPE_PPN_LSB];
			next_valid = entry_low[`MMUPE_VALID_BIT];
			next_attr = entry_low[`MMUPE_ATTR_MSB:`MMUPE_ATTR_LSB];
			next_vpn = virtual_page_number;
			next_address_space_id = address_space_id;
		end
	end

	// output registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr <= 1'b0;
			physical_page_number <= '0;
			valid <= 1'b0;
			attr <= '0;
			wr_vpn <= '0;
			wr_address_space_id <= '0;
		end else begin
			wr <= next_wr;
			physical_page_number <= next_ppn;
			valid <= next_valid;
			attr <= next_attr;
			wr_vpn <= next_vpn;
			wr_address_space_id <= next_address_space_id;
		end
	end

endmodule : mmupe_tlb_load

// File: logic/mmupe_regs.sv
// mmupe_regs.sv: page entry low, page table base and exception address registers of the mmu
// assumes: core-side register port and exception/load strobes are on SYS_CLK; tlb lookup lives elsewhere
// manual reset comes from logic on SYS_CLK as well, so it is used without a synchroniser
//
// What this block does
// - entry low holds ppn and attributes for tlb
// - hardware never changes entry low by itself
// - ppn bits 28-10, valid bit 8, attributes 7-0
// - table base is full 32-bit read/write
// - hardware never changes table base
// - table base has no hardware function
// - exceptions capture faulting virtual address
// - software writes replace the exception address unless a capture lands in the same cycle
// - load also writes vpn and address_space_id
`include "mmupe_defs.svh"

module mmupe_regs
	import mmupe_pkg::*;
(
	// clock and resets
	input wire logic SYS_CLK,
	input wire logic NRST,
	input wire logic MANUAL_NRST,
	// register access port
	input wire logic REG_SEL,
	input wire logic REG_WE,
	input wire mmupe_pkg::mmupe_addr_type REG_ADDR,
	input wire mmupe_pkg::mmupe_word_type REG_WDATA,
	output mmupe_pkg::mmupe_word_type REG_RDATA,
	output logic REG_RVALID,
	// exception capture
	input wire logic EXC_CAPTURE,
	input wire mmupe_pkg::mmupe_word_type EXC_VADDR,
	// load-tlb instruction and entry high contents
	input wire logic LOAD_TLB,
	input wire logic [`MMUPE_VPN_W-1:0] ENTRY_HIGH_VPN,
	input wire logic [`MMUPE_ADDRESS_SPACE_ID_W-1:0] ENTRY_HIGH_ADDRESS_SPACE_ID,
	// unified tlb write
	output logic TLB_WRITE,
	output logic [`MMUPE_PPN_MSB-`MMUPE_PPN_LSB:0] TLB_PPN,
	output logic TLB_VALID,
	output logic [`MMUPE_ATTR_MSB:0] TLB_ATTR,
	output logic [`MMUPE_VPN_W-1:0] TLB_VPN,
	output logic [`MMUPE_ADDRESS_SPACE_ID_W-1:0] TLB_ADDRESS_SPACE_ID
);
	import mmupe_pkg::*;

	// staged registers and their next values
	mmupe_word_type page_entry_low;
	mmupe_word_type page_table_base;
	mmupe_word_type exception_address;
	mmupe_word_type next_page_entry_low;
	mmupe_word_type next_page_table_base;
	mmupe_word_type next_exception_address;
	mmupe_word_type next_rdata;
	logic next_rvalid;
	// decoded offset and per-register write strobes
	mmupe_sel_type sel;
	logic wr_low;
	logic wr_base;
	logic wr_exc;

	// access decode
	// one shared decode keeps the write and read paths agreeing on the offsets
	assign sel = mmupe_decode(REG_ADDR);
	assign wr_low = REG_SEL && REG_WE && (sel == MMUPE_SEL_ENTRY_LOW);
	assign wr_base = REG_SEL && REG_WE && (sel == MMUPE_SEL_TABLE_BASE);
	assign wr_exc = REG_SEL && REG_WE && (sel == MMUPE_SEL_EXC_ADDR);

	// register next values; only software writes move entry low and table base
	always_comb begin
		next_page_entry_low = page_entry_low;
		next_page_table_base = page_table_base;
		next_exception_address = exception_address;
		if (wr_low)
			next_page_entry_low = REG_WDATA & `MMUPE_ENTRY_LOW_MASK;
		if (wr_base)
			next_page_table_base = REG_WDATA;
		// a fault in the same cycle as a software write wins, so no faulting address is lost
		if (EXC_CAPTURE)
			next_exception_address = EXC_VADDR;
		else if (wr_exc)
			next_exception_address = REG_WDATA;
	end

	// registers; a manual reset keeps the exception address so handlers can still read it
	// power-on reset clears all three; zero keeps runs repeatable where the value is otherwise undefined
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			page_entry_low <= `MMUPE_ENTRY_LOW_RST;
			page_table_base <= `MMUPE_TABLE_BASE_RST;
			exception_address <= `MMUPE_EXC_ADDR_RST;
		end else if (!MANUAL_NRST) begin
			page_entry_low <= `MMUPE_ENTRY_LOW_RST;
			page_table_base <= `MMUPE_TABLE_BASE_RST;
			exception_address <= next_exception_address;
		end else begin
			page_entry_low <= next_page_entry_low;
			page_table_base <= next_page_table_base;
			exception_address <= next_exception_address;
		end
	end

	// read data; unmapped offsets return zero, table base only feeds this path
	// a write cycle returns zero as well, so rdata is only meaningful with rvalid
	always_comb begin
		next_rvalid = REG_SEL && !REG_WE;
		next_rdata = `MMUPE_RDATA_RST;
		if (REG_SEL && !REG_WE) begin
			case (sel)
				MMUPE_SEL_ENTRY_LOW: next_rdata = page_entry_low;
				MMUPE_SEL_TABLE_BASE: next_rdata = page_table_base;
				MMUPE_SEL_EXC_ADDR: next_rdata = exception_address;
				default: next_rdata = `MMUPE_RDATA_RST;
			endcase
		end
	end

	// read registers
	// rvalid follows each read strobe by one cycle and rdata drops back to zero with it
	always_ff @(posedge SYS_CLK) begin
		if (!NRST) begin
			REG_RDATA <= `MMUPE_RDATA_RST;
			REG_RVALID <= 1'b0;
		end else begin
			REG_RDATA <= next_rdata;
			REG_RVALID <= next_rvalid;
		end
	end

	// tlb write builder; reads the staged entry as it stands before any same-cycle write
	// so a load and a write of entry low in one cycle hand the old entry to the tlb
	mmupe_tlb_load u_load (
		.clk(SYS_CLK),
		.rst_n(NRST),
		.load(LOAD_TLB),
		.entry_low(page_entry_low),
		.virtual_page_number(ENTRY_HIGH_VPN),
		.address_space_id(ENTRY_HIGH_ADDRESS_SPACE_ID),
		.wr(TLB_WRITE),
		.physical_page_number(TLB_PPN),
		.valid(TLB_VALID),
		.attr(TLB_ATTR),
		.wr_vpn(TLB_VPN),
		.wr_address_space_id(TLB_ADDRESS_SPACE_ID)
	);

	// checks; all on SYS_CLK and quiet while power-on reset is low
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!NRST);

	// a read strobe for each register, as seen at the edge that takes it
	sequence read_low;
		REG_SEL && !REG_WE && sel == MMUPE_SEL_ENTRY_LOW;
	endsequence
	sequence read_base;
		REG_SEL && !REG_WE && sel == MMUPE_SEL_TABLE_BASE;
	endsequence
	sequence read_exc;
		REG_SEL && !REG_WE && sel == MMUPE_SEL_EXC_ADDR;
	endsequence

	// a table base write answered by a read of it in the very next cycle
	sequence base_write_then_read;
		wr_base && MANUAL_NRST ##1 read_base;
	endsequence

	// a load strobe and the tlb write it launches one cycle later
	sequence load_issued;
		LOAD_TLB ##1 TLB_WRITE;
	endsequence

	// entry low: only software or a reset moves it, reserved bits stay clear
	chk_low_reserved_zero: assert property ((page_entry_low[31:29] == 3'h0) && !page_entry_low[9])
		else $error("entry low reserved bits not zero");
	chk_low_hold_steady: assert property (!wr_low && MANUAL_NRST |=> $stable(page_entry_low))
		else $error("entry low changed without a write");
	chk_low_write_fields: assert property (wr_low && MANUAL_NRST |=>
		page_entry_low == ($past(REG_WDATA) & `MMUPE_ENTRY_LOW_MASK))
		else $error("entry low write wrong");
	chk_low_read_back: assert property (read_low |=>
		REG_RVALID && REG_RDATA == $past(page_entry_low))
		else $error("entry low read back wrong");
	chk_manual_clear_regs: assert property (!MANUAL_NRST |=>
		page_entry_low == `MMUPE_ENTRY_LOW_RST && page_table_base == `MMUPE_TABLE_BASE_RST)
		else $error("manual reset left entry low or table base set");

	// table base: a plain scratch word
	chk_base_hold_steady: assert property (!wr_base && MANUAL_NRST |=> $stable(page_table_base))
		else $error("table base changed without a write");
	chk_base_write_read: assert property (base_write_then_read |=>
		REG_RVALID && REG_RDATA == $past(REG_WDATA, 2))
		else $error("table base write not read back");
	chk_base_read_back: assert property (read_base |=>
		REG_RVALID && REG_RDATA == $past(page_table_base))
		else $error("table base read back wrong");

	// exception address: capture beats a same-cycle write, manual reset keeps it
	chk_exc_capture_addr: assert property (EXC_CAPTURE |=> exception_address == $past(EXC_VADDR))
		else $error("faulting address not captured");
	chk_exc_sw_write: assert property (wr_exc && !EXC_CAPTURE |=> exception_address == $past(REG_WDATA))
		else $error("exception address write lost");
	chk_exc_read_back: assert property (read_exc |=>
		REG_RVALID && REG_RDATA == $past(exception_address))
		else $error("exception address read back wrong");
	chk_exc_manual_keep: assert property (!MANUAL_NRST && !EXC_CAPTURE && !wr_exc |=>
		$stable(exception_address))
		else $error("manual reset changed the exception address");

	// tlb write: one pulse per load, fields taken from the entry before the load edge and held
	chk_load_write_pulse: assert property (LOAD_TLB |=> TLB_WRITE)
		else $error("load gave no tlb write");
	chk_load_ppn_copy: assert property (load_issued |->
		TLB_PPN == $past(page_entry_low[`MMUPE_PPN_MSB:`MMUPE_PPN_LSB])
		&& TLB_VALID == $past(page_entry_low[`MMUPE_VALID_BIT])
		&& TLB_ATTR == $past(page_entry_low[`MMUPE_ATTR_MSB:`MMUPE_ATTR_LSB]))
		else $error("tlb entry low fields wrong");
	chk_load_high_copy: assert property (LOAD_TLB |=>
		TLB_VPN == $past(ENTRY_HIGH_VPN) && TLB_ADDRESS_SPACE_ID == $past(ENTRY_HIGH_ADDRESS_SPACE_ID))
		else $error("tlb vpn or address_space_id wrong");
	chk_tlb_fields_hold: assert property (!LOAD_TLB |=>
		!TLB_WRITE && $stable(TLB_PPN) && $stable(TLB_VALID)
		&& $stable(TLB_ATTR) && $stable(TLB_VPN) && $stable(TLB_ADDRESS_SPACE_ID))
		else $error("tlb write or fields moved without a load");
	chk_tlb_write_cause: assert property (TLB_WRITE |-> $past(LOAD_TLB))
		else $error("tlb write without load");

endmodule : mmupe_regs

// File: tb/mmupe_tlb_model.sv
// mmupe_tlb_model.sv: unified tlb write port seen from the far side, packs each write into one entry word
// assumes: tlb write fields are registered by the block and stand while the write strobe is high
module mmupe_tlb_model (
	// write strobe
	input wire logic wr,
	// entry fields
	input wire logic [18:0] physical_page_number,
	input wire logic valid,
	input wire logic [7:0] attr,
	input wire logic [21:0] virtual_page_number,
	input wire logic [7:0] address_space_id,
	// packed entry seen by the bench
	output logic got,
	output logic [57:0] entry
);
	timeunit 1ns;
	timeprecision 1ns;
	// the tlb takes the entry in the strobe cycle, so nothing is delayed here
	assign got = wr;
	assign entry = {physical_page_number, valid, attr, virtual_page_number, address_space_id};
endmodule : mmupe_tlb_model

// File: tb/mmupe_regs_tb.sv
// mmupe_regs_tb.sv: self-checking bench of the mmu page entry staging registers
// assumes: one 100 MHz clock; reads answer one cycle after the strobe, tlb writes one cycle after the load
`include "mmupe_defs.svh"

module mmupe_regs_tb
	import mmupe_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic SYS_CLK = 0, NRST = 0, MANUAL_NRST = 1, REG_SEL = 0, REG_WE = 0, EXC_CAPTURE = 0, LOAD_TLB = 0;
	mmupe_addr_type REG_ADDR = '0;
	mmupe_word_type REG_WDATA = '0, EXC_VADDR = '0, REG_RDATA;
	logic [21:0] ENTRY_HIGH_VPN = '0, TLB_VPN;
	logic [7:0] ENTRY_HIGH_ADDRESS_SPACE_ID = '0, TLB_ATTR, TLB_ADDRESS_SPACE_ID;
	logic [18:0] TLB_PPN;
	logic REG_RVALID, TLB_WRITE, TLB_VALID, got;
	logic [57:0] entry;
	logic [57:0] exp_q[$];
	logic [31:0] v, el, tbase, ea;
	int num_errors = 0, n_checks = 0, seed, i;
	mmupe_regs i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .MANUAL_NRST(MANUAL_NRST), .REG_SEL(REG_SEL),
		.REG_WE(REG_WE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
		.REG_RVALID(REG_RVALID), .EXC_CAPTURE(EXC_CAPTURE), .EXC_VADDR(EXC_VADDR), .LOAD_TLB(LOAD_TLB),
		.ENTRY_HIGH_VPN(ENTRY_HIGH_VPN), .ENTRY_HIGH_ADDRESS_SPACE_ID(ENTRY_HIGH_ADDRESS_SPACE_ID), .TLB_WRITE(TLB_WRITE),
		.TLB_PPN(TLB_PPN), .TLB_VALID(TLB_VALID), .TLB_ATTR(TLB_ATTR), .TLB_VPN(TLB_VPN), .TLB_ADDRESS_SPACE_ID(TLB_ADDRESS_SPACE_ID));
	mmupe_tlb_model i_tlb (.wr(TLB_WRITE), .physical_page_number(TLB_PPN), .valid(TLB_VALID), .attr(TLB_ATTR), .virtual_page_number(TLB_VPN),
		.address_space_id(TLB_ADDRESS_SPACE_ID), .got(got), .entry(entry));
	// clock
	initial begin
		forever #5 SYS_CLK = ~SYS_CLK;
	end
	// one cycle of stimulus; each strobe, the address and the write data are assigned once, so back-to-back calls never glitch
	task automatic step(input logic s, w, input logic [7:0] a, input logic [31:0] d, input logic ld, ex);
		REG_SEL = s;
		REG_WE = w;
		REG_ADDR = a;
		REG_WDATA = d;
		LOAD_TLB = ld;
		EXC_CAPTURE = ex;
		@(posedge SYS_CLK);
		#1;
	endtask : step
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back({26'h0000000, e});
		step(1, 0, a, 0, 0, 0);
	endtask : rd
	task automatic chk(input string nm, input logic [57:0] seen);
		logic [57:0] e;
		n_checks++;
		if (exp_q.size() == 0) begin
			num_errors++;
			$display("[FAIL] %s expected nothing seen %h", nm, seen);
		end else begin
			e = exp_q.pop_front();
			if (e !== seen) begin
				num_errors++;
				$display("[FAIL] %s expected %h seen %h", nm, e, seen);
			end
		end
	endtask : chk
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : test_done
	// sampled at the falling edge, well clear of the registered updates
	always @(negedge SYS_CLK) begin
		if (REG_RVALID === 1'b1)
			chk("read data", {26'h0000000, REG_RDATA});
		if (got === 1'b1)
			chk("tlb entry", entry);
	end
	initial begin
		seed = 77061;
		repeat (20) @(posedge SYS_CLK);
		#1 NRST = 1;
		rd(8'h04, 0);
		rd(8'h08, 0);
		rd(8'h0C, 0);
		$display("reset values done");
		// write then read straight after, reserved bits of entry low must stay clear
		for (i = 0; i < 8; i++) begin
			el = $random(seed);
			tbase = $random(seed);
			step(1, 1, 8'h04, el, 0, 0);
			rd(8'h04, el & `MMUPE_ENTRY_LOW_MASK);
			step(1, 1, 8'h08, tbase, 0, 0);
			rd(8'h08, tbase);
		end
		el = el & `MMUPE_ENTRY_LOW_MASK;
		step(1, 1, 8'h10, 32'hFFFFFFFF, 0, 0);
		rd(8'h10, 0);
		$display("read write done");
		// capture, software overwrite, then capture racing a write
		ea = $random(seed);
		EXC_VADDR = ea;
		step(0, 0, 0, 0, 0, 1);
		rd(8'h0C, ea);
		v = $random(seed);
		step(1, 1, 8'h0C, v, 0, 0);
		rd(8'h0C, v);
		ea = $random(seed);
		EXC_VADDR = ea;
		step(1, 1, 8'h0C, ~ea, 0, 1);
		rd(8'h0C, ea);
		rd(8'h04, el);
		rd(8'h08, tbase);
		$display("exception address done");
		// back-to-back loads, each racing a write of entry low
		for (i = 0; i < 4; i++) begin
			ENTRY_HIGH_VPN = 22'($random(seed));
			ENTRY_HIGH_ADDRESS_SPACE_ID = 8'($random(seed));
			exp_q.push_back({el[28:10], el[8], el[7:0], ENTRY_HIGH_VPN, ENTRY_HIGH_ADDRESS_SPACE_ID});
			v = $random(seed);
			step(1, 1, 8'h04, v, 1, 0);
			el = v & `MMUPE_ENTRY_LOW_MASK;
		end
		step(0, 0, 0, 0, 0, 0);
		rd(8'h04, el);
		rd(8'h08, tbase);
		$display("tlb load done");
		// manual reset keeps only the exception address
		MANUAL_NRST = 0;
		step(0, 0, 0, 0, 0, 0);
		MANUAL_NRST = 1;
		rd(8'h04, 0);
		rd(8'h08, 0);
		rd(8'h0C, ea);
		step(0, 0, 0, 0, 0, 0);
		$display("manual reset done");
		for (i = 0; i < 10 && exp_q.size() > 0; i++)
			@(posedge SYS_CLK);
		if (exp_q.size() > 0) begin
			num_errors++;
			$display("[FAIL] pending results expected 0 seen %0d", exp_q.size());
		end
		test_done();
	end
endmodule : mmupe_regs_tb
